// File: common/fanct_pkg.sv
// Purpose: Shared constants and types for the fan controller serial slave port.
// Assumes: Eight-bit registers selected by an eight-bit command code.
// Notes:   Read-only measurement registers are held at their power-up values here.
`default_nettype none
package fanct_pkg;

   // Fixed seven-bit slave address, binary 0011011.
   localparam logic [6:0] FANCT_OWN_ADDR    = 7'h1B;

   // Command codes that select a register.
   localparam logic [7:0] FANCT_CMD_RPM1    = 8'h00;
   localparam logic [7:0] FANCT_CMD_RPM2    = 8'h01;
   localparam logic [7:0] FANCT_CMD_LIMIT1  = 8'h02;
   localparam logic [7:0] FANCT_CMD_LIMIT2  = 8'h03;
   localparam logic [7:0] FANCT_CMD_CFG     = 8'h04;
   localparam logic [7:0] FANCT_CMD_STATUS  = 8'h05;
   localparam logic [7:0] FANCT_CMD_DUTY    = 8'h06;
   localparam logic [7:0] FANCT_CMD_MFR     = 8'h07;
   localparam logic [7:0] FANCT_CMD_VER     = 8'h08;

   // Power-up values.
   localparam logic [7:0] FANCT_DEF_RPM     = 8'h00;
   localparam logic [7:0] FANCT_DEF_LIMIT   = 8'h0A;
   localparam logic [7:0] FANCT_DEF_CFG     = 8'h0A;
   localparam logic [7:0] FANCT_DEF_STATUS  = 8'h00;
   localparam logic [7:0] FANCT_DEF_DUTY    = 8'h02;
   localparam logic [7:0] FANCT_DEF_UNUSED  = 8'h00;

   // Position of the shutdown_request_bit in the configuration register.
   localparam int         FANCT_CFG_SHUTDOWN = 0;

   // Clock rises that make up one byte on the wire.
   localparam logic [3:0] FANCT_BYTE_BITS   = 4'h8;

   typedef enum logic [3:0] {
      FANCT_ST_IDLE      = 4'b0000,
      FANCT_ST_ADDR      = 4'b0001,
      FANCT_ST_ADDR_ACK  = 4'b0010,
      FANCT_ST_CMD       = 4'b0011,
      FANCT_ST_CMD_ACK   = 4'b0100,
      FANCT_ST_WDATA     = 4'b0101,
      FANCT_ST_WDATA_ACK = 4'b0110,
      FANCT_ST_RDATA     = 4'b0111,
      FANCT_ST_RDATA_ACK = 4'b1000
   } fanct_state_t;

endpackage
`default_nettype wire

// File: src/fanct_sync_filter.sv
// Purpose: Two-stage synchroniser and glitch filter for the serial pins.
// Assumes: The sampling clock runs well above the serial clock rate.
// Notes:   Output moves only after FILTER_LEN equal synchronised samples.
`timescale 1ns/1ps
`default_nettype none
module fanct_sync_filter #(
   parameter int WIDTH      = 2,
   parameter int FILTER_LEN = 3
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Raw pins and filtered result
   input  wire logic [WIDTH-1:0] din,
   output var  logic [WIDTH-1:0] dout
);

   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
         logic                  meta;
         logic                  sync;
         logic                  filt;
         logic [FILTER_LEN-1:0] hist;

         // The first stage feeds the second stage only.
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta <= 1'b1;
               sync <= 1'b1;
            end else begin
               meta <= din[g];
               sync <= meta;
            end
         end

         // Idle bus lines are high, so the history starts high.
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               hist <= '1;
               filt <= 1'b1;
            end else begin
               hist <= {hist[FILTER_LEN-2:0], sync};
               if (&hist) begin
                  filt <= 1'b1;
               end else if (~|hist) begin
                  filt <= 1'b0;
               end
            end
         end

         // Each lane owns one output bit, so no bit has two writers.
         assign dout[g] = filt;
      end
   endgenerate

endmodule
`default_nettype wire

// File: src/fanct_slave_port.sv
// Purpose: Two-wire slave port, register file and shutdown control of a fan controller.
// Assumes: LINK_CLK oversamples the serial clock; CLK drives the fan logic outside.
// Notes:   Only the shutdown bit of the configuration register crosses to CLK, as a single synchronised level.
`timescale 1ns/1ps
`default_nettype none
module fanct_slave_port
   import fanct_pkg::*;
#(
   parameter int         FILTER_LEN = 3,
   parameter logic [7:0] MFR_CODE   = 8'hA5,  // Arbitrary value.
   parameter logic [7:0] VER_CODE   = 8'h01   // Arbitrary value.
) (
   // Core clock and reset
   input  wire logic       CLK,
   input  wire logic       RST_N,
   // Serial link
   input  wire logic       LINK_CLK,
   input  wire logic       SCL_I,
   input  wire logic       SDA_I,
   output var  logic       SDA_O,
   output var  logic       SDA_OE,
   // Settings for the fan logic, in the LINK_CLK domain
   output var  logic [7:0] CFG_OUT,
   output var  logic [7:0] LIMIT1_OUT,
   output var  logic [7:0] LIMIT2_OUT,
   output var  logic [7:0] DUTY_OUT,
   // Run control, in the CLK domain
   output var  logic       FUNC_RUN,
   output var  logic       RESUME_PULSE
);

   fanct_state_t state;
   logic [1:0]   line_f;
   logic         scl_f;
   logic         sda_f;
   logic         scl_prev;
   logic         sda_prev;
   logic         start_det;
   logic         stop_det;
   logic         scl_rise;
   logic         scl_fall;
   logic [3:0]   bit_cnt;
   logic         byte_done;
   logic [7:0]   shreg;
   logic         rw;
   logic         nack;
   logic [7:0]   pointer;
   logic [7:0]   rd_data;
   logic         ptr_stb;
   logic         wr_stb;
   logic [7:0]   cfg;
   logic [7:0]   limit1;
   logic [7:0]   limit2;
   logic [7:0]   duty;
   logic         shut_meta;
   logic         shut_sync;
   logic         shut_prev;

   function automatic logic is_writable(input logic [7:0] code);
      is_writable = (code == FANCT_CMD_LIMIT1) || (code == FANCT_CMD_LIMIT2) ||
                    (code == FANCT_CMD_CFG) || (code == FANCT_CMD_DUTY);
   endfunction

   // The sampled pins pass two flops and a filter so a slow edge cannot fake a Start.
   fanct_sync_filter #(
      .WIDTH      (2),
      .FILTER_LEN (FILTER_LEN)
   ) u_filter (
      .clk   (LINK_CLK),
      .rst_n (RST_N),
      .din   ({SCL_I, SDA_I}),
      .dout  (line_f)
   );

   assign scl_f = line_f[1];
   assign sda_f = line_f[0];

   always_ff @(posedge LINK_CLK or negedge RST_N) begin
      if (!RST_N) begin
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_prev <= scl_f;
         sda_prev <= sda_f;
      end
   end

   assign start_det = scl_f & scl_prev & sda_prev & ~sda_f;
   assign stop_det  = scl_f & scl_prev & ~sda_prev & sda_f;
   assign scl_rise  = scl_f & ~scl_prev;
   assign scl_fall  = ~scl_f & scl_prev;
   assign byte_done = scl_fall && (bit_cnt == FANCT_BYTE_BITS);
   assign ptr_stb   = (state == FANCT_ST_CMD) && byte_done;
   assign wr_stb    = (state == FANCT_ST_WDATA) && byte_done;

   // Register selected by the latest command; unused codes read zero.
   always_comb begin
      case (pointer)
         FANCT_CMD_RPM1:   rd_data = FANCT_DEF_RPM;
         FANCT_CMD_RPM2:   rd_data = FANCT_DEF_RPM;
         FANCT_CMD_LIMIT1: rd_data = limit1;
         FANCT_CMD_LIMIT2: rd_data = limit2;
         FANCT_CMD_CFG:    rd_data = cfg;
         FANCT_CMD_STATUS: rd_data = FANCT_DEF_STATUS;
         FANCT_CMD_DUTY:   rd_data = duty;
         FANCT_CMD_MFR:    rd_data = MFR_CODE;
         FANCT_CMD_VER:    rd_data = VER_CODE;
         default:          rd_data = FANCT_DEF_UNUSED;
      endcase
   end

   // Byte engine. It only ever drives data low; the clock is never driven.
   always_ff @(posedge LINK_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state   <= FANCT_ST_IDLE;
         bit_cnt <= 4'h0;
         shreg   <= 8'h00;
         rw      <= 1'b0;
         nack    <= 1'b1;
         SDA_OE  <= 1'b0;
      end else if (start_det) begin
         state   <= FANCT_ST_ADDR;
         bit_cnt <= 4'h0;
         SDA_OE  <= 1'b0;
      end else if (stop_det) begin
         state  <= FANCT_ST_IDLE;
         SDA_OE <= 1'b0;
      end else if (scl_rise) begin
         bit_cnt <= bit_cnt + 4'h1;
         if ((state == FANCT_ST_ADDR) || (state == FANCT_ST_CMD) ||
             (state == FANCT_ST_WDATA)) begin
            shreg <= {shreg[6:0], sda_f};
         end
         if (state == FANCT_ST_RDATA_ACK) begin
            nack <= sda_f;
         end
      end else if (scl_fall) begin
         case (state)
            FANCT_ST_ADDR: begin
               if (byte_done) begin
                  if (shreg[7:1] == FANCT_OWN_ADDR) begin
                     rw     <= shreg[0];
                     SDA_OE <= 1'b1;
                     state  <= FANCT_ST_ADDR_ACK;
                  end else begin
                     state <= FANCT_ST_IDLE;
                  end
               end
            end
            FANCT_ST_ADDR_ACK: begin
               bit_cnt <= 4'h0;
               if (rw) begin
                  shreg  <= rd_data;
                  SDA_OE <= ~rd_data[7];
                  state  <= FANCT_ST_RDATA;
               end else begin
                  SDA_OE <= 1'b0;
                  state  <= FANCT_ST_CMD;
               end
            end
            FANCT_ST_CMD: begin
               if (byte_done) begin
                  SDA_OE <= 1'b1;
                  state  <= FANCT_ST_CMD_ACK;
               end
            end
            FANCT_ST_CMD_ACK: begin
               bit_cnt <= 4'h0;
               SDA_OE  <= 1'b0;
               state   <= FANCT_ST_WDATA;
            end
            FANCT_ST_WDATA: begin
               if (byte_done) begin
                  SDA_OE <= 1'b1;
                  state  <= FANCT_ST_WDATA_ACK;
               end
            end
            FANCT_ST_WDATA_ACK: begin
               bit_cnt <= 4'h0;
               SDA_OE  <= 1'b0;
               state   <= FANCT_ST_WDATA;
            end
            FANCT_ST_RDATA: begin
               if (byte_done) begin
                  SDA_OE <= 1'b0;
                  state  <= FANCT_ST_RDATA_ACK;
               end else begin
                  shreg  <= {shreg[6:0], 1'b0};
                  SDA_OE <= ~shreg[6];
               end
            end
            FANCT_ST_RDATA_ACK: begin
               bit_cnt <= 4'h0;
               if (!nack) begin
                  shreg  <= rd_data;
                  SDA_OE <= ~rd_data[7];
                  state  <= FANCT_ST_RDATA;
               end else begin
                  SDA_OE <= 1'b0;
                  state  <= FANCT_ST_IDLE;
               end
            end
            default: begin
               SDA_OE <= 1'b0;
            end
         endcase
      end
   end

   // The pin level when driven is always low; the enable does the work.
   always_ff @(posedge LINK_CLK or negedge RST_N) begin
      if (!RST_N) begin
         SDA_O <= 1'b0;
      end else begin
         SDA_O <= 1'b0;
      end
   end

   // Command byte persists so a later receive-byte reads the same register.
   always_ff @(posedge LINK_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pointer <= 8'h00;
      end else if (ptr_stb) begin
         pointer <= shreg;
      end
   end

   // Register file stays in the link domain so it works during shutdown.
   always_ff @(posedge LINK_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cfg    <= FANCT_DEF_CFG;
         limit1 <= FANCT_DEF_LIMIT;
         limit2 <= FANCT_DEF_LIMIT;
         duty   <= FANCT_DEF_DUTY;
      end else if (wr_stb) begin
         case (pointer)
            FANCT_CMD_LIMIT1: limit1 <= shreg;
            FANCT_CMD_LIMIT2: limit2 <= shreg;
            FANCT_CMD_CFG: begin
               cfg <= shreg;
               if (cfg[FANCT_CFG_SHUTDOWN] && !shreg[FANCT_CFG_SHUTDOWN]) begin
                  duty <= FANCT_DEF_DUTY;
               end
            end
            FANCT_CMD_DUTY:   duty <= shreg;
            default: begin
            end
         endcase
      end
   end

   assign CFG_OUT    = cfg;
   assign LIMIT1_OUT = limit1;
   assign LIMIT2_OUT = limit2;
   assign DUTY_OUT   = duty;

   // Core side sees only a level, so a plain two-flop synchroniser is enough.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         shut_meta <= 1'b0;
         shut_sync <= 1'b0;
         shut_prev <= 1'b0;
      end else begin
         shut_meta <= cfg[FANCT_CFG_SHUTDOWN];
         shut_sync <= shut_meta;
         shut_prev <= shut_sync;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         FUNC_RUN     <= 1'b0;
         RESUME_PULSE <= 1'b0;
      end else begin
         FUNC_RUN     <= ~shut_sync;
         RESUME_PULSE <= shut_prev & ~shut_sync;
      end
   end

   // Checks on the link and core domains.
   a_own_addr_ack: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
      (state == FANCT_ST_ADDR && byte_done && shreg[7:1] == FANCT_OWN_ADDR)
      |=> (state == FANCT_ST_ADDR_ACK) && SDA_OE)
      else $error("Own address not acknowledged.");

   a_foreign_addr_quiet: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
      (state == FANCT_ST_ADDR && byte_done && shreg[7:1] != FANCT_OWN_ADDR)
      |=> (state == FANCT_ST_IDLE) && !SDA_OE)
      else $error("Foreign address drew a response.");

   a_dir_read: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
      (state == FANCT_ST_ADDR_ACK && scl_fall && !start_det && !stop_det)
      |=> (state == (rw ? FANCT_ST_RDATA : FANCT_ST_CMD)))
      else $error("Direction bit not followed.");

   a_start_restart: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
      start_det |=> (state == FANCT_ST_ADDR) && (bit_cnt == 4'h0) && !SDA_OE)
      else $error("Start did not begin address reception.");

   a_stop_ends: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
      (stop_det && !start_det) |=> (state == FANCT_ST_IDLE) && !SDA_OE)
      else $error("Stop did not end the transfer.");

   a_drive_clock_low: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
      $rose(SDA_OE) |-> !scl_f)
      else $error("Data drive began while clock high.");

   a_tx_msb_first: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
      (state != FANCT_ST_RDATA ##1 state == FANCT_ST_RDATA) |-> (SDA_OE == ~shreg[7]))
      else $error("First transmitted bit is not the top bit.");

   a_ack_held: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
      (state == FANCT_ST_ADDR_ACK || state == FANCT_ST_CMD_ACK ||
       state == FANCT_ST_WDATA_ACK) |-> SDA_OE)
      else $error("Acknowledge released early.");

   a_nack_release: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
      (state == FANCT_ST_RDATA_ACK && scl_fall && nack && !start_det && !stop_det)
      |=> !SDA_OE && (state == FANCT_ST_IDLE))
      else $error("Data line not released after a withheld acknowledge.");

   a_exit_reload: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
      (wr_stb && pointer == FANCT_CMD_CFG && cfg[FANCT_CFG_SHUTDOWN] &&
       !shreg[FANCT_CFG_SHUTDOWN])
      |=> (duty == FANCT_DEF_DUTY) && $stable(limit1) && $stable(limit2))
      else $error("Shutdown exit did not reload defaults.");

   a_readonly_ignored: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
      (wr_stb && !is_writable(pointer)) |=> $stable({cfg, limit1, limit2, duty}))
      else $error("Write to a read-only code changed a register.");

   a_run_suspend: assert property (@(posedge CLK) disable iff (!RST_N)
      $rose(shut_sync) |=> !FUNC_RUN ##1 !FUNC_RUN || !shut_sync)
      else $error("Functions not suspended in shutdown.");

   a_run_resume: assert property (@(posedge CLK) disable iff (!RST_N)
      $fell(shut_sync) |=> FUNC_RUN && RESUME_PULSE)
      else $error("Functions not resumed on shutdown exit.");

   c_write_byte: cover property (@(posedge LINK_CLK) disable iff (!RST_N)
      wr_stb ##[1:300] stop_det);

   c_read_nack: cover property (@(posedge LINK_CLK) disable iff (!RST_N)
      state == FANCT_ST_RDATA_ACK && scl_fall && nack);

   c_foreign_addr: cover property (@(posedge LINK_CLK) disable iff (!RST_N)
      state == FANCT_ST_ADDR && byte_done && shreg[7:1] != FANCT_OWN_ADDR);

   c_shutdown_exit: cover property (@(posedge CLK) disable iff (!RST_N)
      $fell(shut_sync));

endmodule
`default_nettype wire

// File: testbench/fanct_host_model.sv
// Purpose: Behavioural two-wire bus master for the fan controller port.
// Assumes: The bench resolves the open-drain data wire with a pull-up.
// Notes:   A quarter bit is 16 CLK cycles, far above the pin filter delay.
`timescale 1ns/1ps
`default_nettype none
module fanct_host_model (
   // Timing reference
   input  wire logic       clk,
   // Bus wires
   input  wire logic       sda_in,
   output var  logic       scl,
   output var  logic       sda_drv,
   // Acknowledge level and byte seen on the wire
   output var  logic [8:0] res,
   output var  logic       res_stb
);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
      res = 9'h000;
      res_stb = 1'b0;
   end
   task automatic q();
      repeat (16) @(posedge clk);
      #1;
   endtask
   // The clock toggles only inside frames, so the data line moves only while it is low.
   task automatic bit_io(input logic b, output logic r);
      sda_drv = b;
      q();
      scl = 1'b1;
      q();
      r = sda_in;
      q();
      scl = 1'b0;
      q();
   endtask
   task automatic start();
      sda_drv = 1'b1;
      q();
      scl = 1'b1;
      q();
      sda_drv = 1'b0;
      q();
      scl = 1'b0;
      q();
   endtask
   task automatic stop();
      sda_drv = 1'b0;
      q();
      scl = 1'b1;
      q();
      sda_drv = 1'b1;
      q();
      q();
   endtask
   task automatic xfer(input logic [7:0] d, input logic mack);
      logic [8:0] r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
      bit_io(mack, r[8]);
      res = r;
      res_stb = ~res_stb;
   endtask
endmodule
`default_nettype wire

// File: testbench/fan_ctrl_smbus_slave_shutdown_tb.sv
// Purpose: Self-checking bench for the fan controller serial port and shutdown.
// Assumes: Default filter length; the host model keeps every bus rule.
// Notes:   Byte results are queued by the driver and compared by a watcher.
`timescale 1ns/1ps
`default_nettype none
module fan_ctrl_smbus_slave_shutdown_tb;
   import fanct_pkg::*;
   localparam logic [7:0] MFR = 8'h3C;  // Arbitrary value.
   localparam logic [7:0] VER = 8'h02;  // Arbitrary value.
   logic       clk = 1'b0;
   logic       link_clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       scl;
   logic       sda_drv;
   logic       sda_o;
   logic       sda_oe;
   wire logic  sda;
   logic [7:0] cfg;
   logic [7:0] lim1;
   logic [7:0] lim2;
   logic [7:0] duty;
   logic       func_run;
   logic       resume;
   logic [8:0] res;
   logic       res_stb;
   logic [8:0] exp_q[$];
   logic [7:0] l1;
   logic [7:0] l2;
   logic [7:0] dv;
   logic [7:0] cv;
   logic [7:0] rcmd[11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                            8'h08, 8'h09, 8'hFF};
   logic [7:0] rexp[11] = '{FANCT_DEF_RPM, FANCT_DEF_RPM, FANCT_DEF_LIMIT,
                            FANCT_DEF_LIMIT, FANCT_DEF_CFG, FANCT_DEF_STATUS,
                            FANCT_DEF_DUTY, MFR, VER, FANCT_DEF_UNUSED, FANCT_DEF_UNUSED};
   logic [6:0] bad[3] = '{7'h1A, 7'h3B, 7'h5B};
   int         err_count = 0;
   int         tests_run = 0;
   int         resumes = 0;
   // Open drain with pull-up: the device can only pull low.
   assign sda = sda_drv & ~(sda_oe & ~sda_o);
   always #50 clk = ~clk;
   initial begin
      #37;
      forever #80 link_clk = ~link_clk;
   end
   fanct_slave_port #(.MFR_CODE(MFR), .VER_CODE(VER)) dut (
      .CLK(clk), .RST_N(rst_n), .LINK_CLK(link_clk), .SCL_I(scl), .SDA_I(sda),
      .SDA_O(sda_o), .SDA_OE(sda_oe), .CFG_OUT(cfg), .LIMIT1_OUT(lim1),
      .LIMIT2_OUT(lim2), .DUTY_OUT(duty), .FUNC_RUN(func_run), .RESUME_PULSE(resume));
   fanct_host_model host (
      .clk(clk), .sda_in(sda), .scl(scl), .sda_drv(sda_drv), .res(res),
      .res_stb(res_stb));
   always @(posedge clk) if (resume === 1'b1) resumes <= resumes + 1;
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic chk8(input logic [7:0] seen, input logic [7:0] exp);
      chk({1'b0, seen}, {1'b0, exp});
   endtask
   always @(res_stb) if ($time > 0) begin
      if (exp_q.size() == 0) begin
         err_count++;
         $display("ERROR t=%0t unexpected byte result", $time);
      end else
         chk(res, exp_q.pop_front());
   end
   task automatic put(input logic [7:0] d, input logic a);
      exp_q.push_back({a, d});
   endtask
   task automatic send(input logic [7:0] d, input logic a);
      put(d, a);
      host.xfer(d, 1'b1);
   endtask
   // Write-byte; earlier extra bytes carry the inverse so only the last one may stick.
   task automatic wr(input logic [7:0] cmd, input logic [7:0] d, input int n);
      host.start();
      send({FANCT_OWN_ADDR, 1'b0}, 1'b0);
      send(cmd, 1'b0);
      for (int i = 1; i <= n; i++) send((i == n) ? d : ~d, 1'b0);
      host.stop();
   endtask
   // Read-byte with a command, or receive-byte without; the last byte is refused.
   task automatic rd(input logic use_cmd, input logic [7:0] cmd, input logic [7:0] e,
                     input int n);
      host.start();
      if (use_cmd) begin
         send({FANCT_OWN_ADDR, 1'b0}, 1'b0);
         send(cmd, 1'b0);
         host.start();
      end
      send({FANCT_OWN_ADDR, 1'b1}, 1'b0);
      for (int i = 1; i <= n; i++) begin
         put(e, i == n);
         host.xfer(8'hFF, i == n);
      end
      host.stop();
      chk8({7'h00, sda_oe}, 8'h00);
   endtask
   task automatic wait_run(input logic v);
      for (int i = 0; i < 40; i++) begin
         if (func_run === v) return;
         @(posedge clk);
      end
      err_count++;
      $display("ERROR t=%0t run level not reached", $time);
      tally_and_finish();
   endtask
   initial begin
      #9000000;
      err_count++;
      $display("ERROR t=%0t run did not complete", $time);
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'h621A2F0A));
      l1 = 8'($urandom);
      l2 = 8'($urandom);
      dv = 8'($urandom) | 8'h80;
      cv = 8'($urandom);
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (20) @(posedge clk);
      chk8(cfg, FANCT_DEF_CFG);
      chk8(lim2, FANCT_DEF_LIMIT);
      chk8({7'h00, func_run}, 8'h01);
      foreach (rcmd[i]) rd(1'b1, rcmd[i], rexp[i], 1);
      foreach (bad[i]) begin
         host.start();
         send({bad[i], 1'b0}, 1'b1);
         host.stop();
      end
      wr(FANCT_CMD_LIMIT1, l1, 1);
      wr(FANCT_CMD_LIMIT2, l2, 1);
      wr(FANCT_CMD_DUTY, dv, 2);
      wr(FANCT_CMD_RPM1, 8'h55, 1);
      wr(8'h0C, 8'h55, 1);
      rd(1'b1, FANCT_CMD_RPM1, FANCT_DEF_RPM, 1);
      chk8(cfg, FANCT_DEF_CFG);
      chk8(lim1, l1);
      chk8(duty, dv);
      wr(FANCT_CMD_CFG, cv | 8'h01, 1);
      wait_run(1'b0);
      rd(1'b1, FANCT_CMD_DUTY, dv, 2);
      wr(FANCT_CMD_CFG, cv & 8'hFE, 1);
      wait_run(1'b1);
      repeat (4) @(posedge clk);
      chk8(8'(resumes), 8'h01);
      chk8(duty, FANCT_DEF_DUTY);
      chk8(lim1, l1);
      chk8(lim2, l2);
      chk8(cfg, cv & 8'hFE);
      rd(1'b0, 8'h00, cv & 8'hFE, 1);
      rd(1'b1, FANCT_CMD_LIMIT2, l2, 2);
      rd(1'b0, 8'h00, l2, 1);
      // A reset in mid-run, with the bus idle, must bring back the power-up values.
      rst_n = 1'b0;
      repeat (6) @(posedge clk);
      #1 chk8({7'h00, func_run}, 8'h00);
      rst_n = 1'b1;
      wait_run(1'b1);
      chk8(lim1, FANCT_DEF_LIMIT);
      chk8(duty, FANCT_DEF_DUTY);
      chk8(8'(resumes), 8'h01);
      rd(1'b0, 8'h00, FANCT_DEF_RPM, 1);
      tally_and_finish();
   end
endmodule
`default_nettype wire
